//--- logic/ssr_part_if.sv
`timescale 1ns/100ps
`default_nettype none
interface ssr_part_if;
    import ssr_pkg::*;
    logic        rd;
    logic        wr;
    ssr_part_t   part;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [15:0] cond_in;
    logic        sum;

    modport ctrl (output rd, output wr, output part, output wdata, output cond_in,
                  input rdata, input sum);
    modport regs (input rd, input wr, input part, input wdata, input cond_in,
                  output rdata, output sum);
endinterface
`default_nettype wire

//--- logic/ssr_pkg.sv
`default_nettype none
package ssr_pkg;

    // Width of every part of a five-part status register.
    localparam int SSR_PART_W = 16;
    // Most significant bit, which must always read as zero.
    localparam int SSR_MSB_BIT = 15;
    localparam logic [15:0] SSR_VALID_MASK = 16'h7fff;
    localparam logic [15:0] SSR_ZERO16 = 16'h0000;

    // Reset values of the filter, event and enable parts.
    localparam logic [15:0] SSR_PTR_RST = 16'h7fff;
    localparam logic [15:0] SSR_NTR_RST = 16'h0000;
    localparam logic [15:0] SSR_EVT_RST = 16'h0000;
    localparam logic [15:0] SSR_ENA_RST = 16'h0000;

    // Status byte layout.
    localparam int SSR_STB_ERRQ = 2;
    localparam int SSR_STB_QUES = 3;
    localparam int SSR_STB_MAV = 4;
    localparam int SSR_STB_ESB = 5;
    localparam int SSR_STB_MSS = 6;
    localparam int SSR_STB_OPER = 7;
    localparam logic [7:0] SSR_ZERO8 = 8'h00;
    localparam logic [7:0] SSR_SRE_MASK = 8'hbc;

    // Error queue defaults.
    localparam int SSR_ERRQ_DEPTH = 16;
    localparam int SSR_ERRQ_W = 16;

    // Part selector of a five-part register.
    typedef enum logic [2:0] {
        SSR_PART_COND   = 3'b000,
        SSR_PART_PTR    = 3'b001,
        SSR_PART_NTR    = 3'b010,
        SSR_PART_EVENT  = 3'b011,
        SSR_PART_ENABLE = 3'b100
    } ssr_part_t;

    // Register selector; the status byte answers cond/event reads and keeps its mask as enable.
    typedef enum logic [1:0] {
        SSR_REG_OPER = 2'b00,
        SSR_REG_QUES = 2'b01,
        SSR_REG_ESR  = 2'b10,
        SSR_REG_STB  = 2'b11
    } ssr_reg_t;

    // Controller operations.
    typedef enum logic [1:0] {
        SSR_OP_READ  = 2'b00,
        SSR_OP_WRITE = 2'b01,
        SSR_OP_POP   = 2'b10,
        SSR_OP_NONE  = 2'b11
    } ssr_op_t;

    // Forces the top bit of a part to zero.
    function automatic logic [15:0] ssr_clip(input logic [15:0] v);
        return v & SSR_VALID_MASK;
    endfunction

endpackage
`default_nettype wire

//--- logic/ssr_status_reg.sv
`timescale 1ns/100ps
`default_nettype none
module ssr_status_reg
    import ssr_pkg::*;
#(
    parameter logic [15:0] PTR_INIT = SSR_PTR_RST,
    parameter logic [15:0] NTR_INIT = SSR_NTR_RST
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // Access and hierarchy port.
    ssr_part_if.regs port
);

    logic [15:0] cond;
    logic [15:0] cond_prev;
    logic [15:0] ptr;
    logic [15:0] ntr;
    logic [15:0] evt;
    logic [15:0] ena;
    logic [15:0] set_bits;
    logic [15:0] next_evt;

    // Condition follows its source live; writes never reach it.
    assign cond = ssr_clip(port.cond_in);

    // Previous condition, kept to spot edges per bit.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cond_prev <= SSR_ZERO16;
        end else begin
            cond_prev <= cond;
        end
    end

    // Each bit is filtered on its own by the matching filter bit.
    assign set_bits = ((cond & ~cond_prev) & ptr)
                    | ((~cond & cond_prev) & ntr);

    // A transition in the same cycle as the clearing read survives it.
    assign next_evt = ssr_clip(((port.rd && port.part == SSR_PART_EVENT) ? SSR_ZERO16 : evt)
                               | set_bits);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            evt <= SSR_EVT_RST;
        end else begin
            evt <= next_evt;
        end
    end

    // Filter and enable parts are plain writable storage.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ptr <= PTR_INIT;
            ntr <= NTR_INIT;
            ena <= SSR_ENA_RST;
        end else if (port.wr) begin
            if (port.part == SSR_PART_PTR) begin
                ptr <= ssr_clip(port.wdata);
            end else if (port.part == SSR_PART_NTR) begin
                ntr <= ssr_clip(port.wdata);
            end else if (port.part == SSR_PART_ENABLE) begin
                ena <= ssr_clip(port.wdata);
            end
        end
    end

    // Read mux; only the event part has a read side effect.
    always_comb begin
        case (port.part)
            SSR_PART_COND:   port.rdata = cond;
            SSR_PART_PTR:    port.rdata = ptr;
            SSR_PART_NTR:    port.rdata = ntr;
            SSR_PART_EVENT:  port.rdata = evt;
            SSR_PART_ENABLE: port.rdata = ena;
            default:         port.rdata = SSR_ZERO16;
        endcase
    end

    assign port.sum = |(evt & ena);

endmodule
`default_nettype wire

//--- logic/ssr_status_top.sv
// Functional notes
// - Each register has five sixteen-bit parts.
// - One source uses one bit in all parts.
// - Bit fifteen of every part reads zero.
// - Condition follows hardware input or lower sum; all three registers here take hardware input only.
// - Condition is read-only and unaffected by reads.
// - Message-available bit follows output queue occupancy.
// - Error queue keeps entries, returns oldest first.
// - Service request enable masks the status byte.
// - Event status enable masks standard event register.
// - Status byte bit two flags queue; 1,0 zero.
// - Status byte gathers operation, questionable, event, request.
// - Rising condition sets event when positive filter set.
// - Falling condition sets event when negative filter set.
// - Event latches transitions, read-only, cleared by reading.
// - Sum is OR of enabled event bits.
`timescale 1ns/100ps
`default_nettype none
module ssr_status_top
    import ssr_pkg::*;
#(
    parameter int ERRQ_DEPTH = SSR_ERRQ_DEPTH,
    parameter int ERRQ_W     = SSR_ERRQ_W
) (
    // Clock and reset.
    input  wire logic              core_clk,
    input  wire logic              rst,
    // Hardware status sources.
    input  wire logic [14:0]       oper_cond_in,
    input  wire logic [14:0]       ques_cond_in,
    input  wire logic [14:0]       std_event_in,
    input  wire logic              out_queue_not_empty,
    // Error and event queue fill side.
    input  wire logic              err_push,
    input  wire logic [ERRQ_W-1:0] err_code,
    output logic                   err_full,
    // Controller access port.
    input  wire logic              cmd_valid,
    input  wire ssr_op_t           cmd_op,
    input  wire ssr_reg_t          cmd_reg,
    input  wire ssr_part_t         cmd_part,
    input  wire logic [15:0]       cmd_wdata,
    output logic                   rsp_valid,
    output logic [15:0]            rsp_data,
    // Status summary outputs.
    output logic [7:0]             status_byte,
    output logic                   srq_pulse
);

    // Queue sizes; the counter is one bit wider so that full and empty differ.
    localparam int AW = (ERRQ_DEPTH > 1) ? $clog2(ERRQ_DEPTH) : 1;
    localparam logic [AW:0] FIFO_FULL = (AW+1)'(ERRQ_DEPTH);
    localparam logic [AW:0] FIFO_ONE = (AW+1)'(1);
    localparam logic [AW-1:0] PTR_ONE = AW'(1);
    localparam logic [AW-1:0] PTR_LAST = AW'(ERRQ_DEPTH - 1);

    // One access bundle for each five-part register.
    ssr_part_if part_bus [3] ();

    // Read data and sum bits gathered back from the registers.
    logic [15:0] reg_rdata [3];
    logic [2:0]  reg_sum;
    logic [15:0] cond_src [3];
    logic [7:0]  sre;
    logic [7:0]  stb_base;
    logic [7:0]  stb_full;
    logic [7:0]  stb_prev;
    logic        mss;
    logic        is_read;
    logic        is_write;
    logic        pop_req;
    logic [15:0] next_rsp_data;

    // Error queue storage and its bookkeeping.
    logic [ERRQ_W-1:0] errq_mem [ERRQ_DEPTH];
    logic [AW-1:0]     errq_wr_ptr;
    logic [AW-1:0]     errq_rd_ptr;
    logic [AW:0]       errq_count;
    logic              errq_empty;
    logic              do_push;
    logic              do_pop;

    // Operation decode; a strobe that carries the idle op changes nothing but the held rsp_data.
    assign is_read  = cmd_valid && cmd_op == SSR_OP_READ;
    assign is_write = cmd_valid && cmd_op == SSR_OP_WRITE;
    assign pop_req  = cmd_valid && cmd_op == SSR_OP_POP;

    // Lowest level: conditions come straight from the hardware sources.
    assign cond_src[0] = {1'b0, oper_cond_in};
    assign cond_src[1] = {1'b0, ques_cond_in};
    assign cond_src[2] = {1'b0, std_event_in};

    // Three five-part registers; the event status one carries its enable mask.
    for (genvar gi = 0; gi < 3; gi++) begin : g_reg
        assign part_bus[gi].rd      = is_read && cmd_reg == ssr_reg_t'(gi);
        assign part_bus[gi].wr      = is_write && cmd_reg == ssr_reg_t'(gi);
        assign part_bus[gi].part    = cmd_part;
        assign part_bus[gi].wdata   = cmd_wdata;
        assign part_bus[gi].cond_in = cond_src[gi];
        assign reg_rdata[gi]        = part_bus[gi].rdata;
        assign reg_sum[gi]          = part_bus[gi].sum;

        ssr_status_reg u_reg (
            .core_clk (core_clk),
            .rst      (rst),
            .port     (part_bus[gi])
        );
    end

    // Status byte without its summary bit; bits 1 and 0 stay zero.
    always_comb begin
        stb_base = SSR_ZERO8;
        stb_base[SSR_STB_ERRQ] = ~errq_empty;
        stb_base[SSR_STB_QUES] = reg_sum[1];
        stb_base[SSR_STB_MAV]  = out_queue_not_empty;
        stb_base[SSR_STB_ESB]  = reg_sum[2];
        stb_base[SSR_STB_OPER] = reg_sum[0];
    end

    // The service request enable acts as the byte's enable part; its bit 6 never counts.
    assign mss = |(stb_base & sre);

    // Full byte with its summary bit in place.
    always_comb begin
        stb_full = stb_base;
        stb_full[SSR_STB_MSS] = mss;
    end

    // Mask storage; bit 6 and the unused low bits are dropped on write.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sre <= SSR_ZERO8;
        end else if (is_write && cmd_reg == SSR_REG_STB && cmd_part == SSR_PART_ENABLE) begin
            sre <= cmd_wdata[7:0] & SSR_SRE_MASK;
        end
    end

    // A request fires when an enabled byte bit rises, so a level held high asks once.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            stb_prev    <= SSR_ZERO8;
            srq_pulse   <= 1'b0;
            status_byte <= SSR_ZERO8;
        end else begin
            stb_prev    <= stb_base;
            srq_pulse   <= |(stb_base & ~stb_prev & sre);
            status_byte <= stb_full;
        end
    end

    // Error queue: a full queue drops the newest entry rather than overwrite history.
    assign errq_empty = errq_count == '0;
    assign err_full   = errq_count == FIFO_FULL;
    assign do_push    = err_push && !err_full;
    assign do_pop     = pop_req && !errq_empty;

    // Storage has no reset, so only the counter decides which words are valid.
    always_ff @(posedge core_clk) begin
        if (do_push) begin
            errq_mem[errq_wr_ptr] <= err_code;
        end
    end

    // Pointers wrap at the depth itself, which need not be a power of two.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            errq_wr_ptr <= '0;
            errq_rd_ptr <= '0;
            errq_count  <= '0;
        end else begin
            if (do_push) begin
                errq_wr_ptr <= (errq_wr_ptr == PTR_LAST) ? '0 : errq_wr_ptr + PTR_ONE;
            end
            if (do_pop) begin
                errq_rd_ptr <= (errq_rd_ptr == PTR_LAST) ? '0 : errq_rd_ptr + PTR_ONE;
            end
            if (do_push && !do_pop) begin
                errq_count <= errq_count + FIFO_ONE;
            end else if (do_pop && !do_push) begin
                errq_count <= errq_count - FIFO_ONE;
            end
        end
    end

    // Answer mux; an empty queue answers zero, meaning no error.
    // Reads of the status byte never clear it, unlike an event part.
    always_comb begin
        next_rsp_data = SSR_ZERO16;
        if (cmd_op == SSR_OP_POP) begin
            if (!errq_empty) begin
                next_rsp_data = 16'(errq_mem[errq_rd_ptr]);
            end
        end else if (cmd_reg == SSR_REG_STB) begin
            if (cmd_part == SSR_PART_ENABLE) begin
                next_rsp_data = {SSR_ZERO8, sre};
            end else begin
                next_rsp_data = {SSR_ZERO8, stb_full};
            end
        end else begin
            next_rsp_data = ssr_clip(reg_rdata[cmd_reg]);
        end
    end

    // Every request is answered on the next edge; nothing stalls the controller.
    // Data holds between requests so that a slow reader still sees its answer.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rsp_valid <= 1'b0;
            rsp_data  <= SSR_ZERO16;
        end else begin
            rsp_valid <= cmd_valid && cmd_op != SSR_OP_NONE;
            if (cmd_valid) begin
                rsp_data <= next_rsp_data;
            end
        end
    end

endmodule
`default_nettype wire

//--- test/ssr_ctl_model.sv
`timescale 1ns/100ps
`default_nettype none
module ssr_ctl_model
    import ssr_pkg::*;
(
    // Clock.
    input wire logic        core_clk,
    // Request lines.
    output var logic        cmd_valid,
    output var ssr_op_t     cmd_op,
    output var ssr_reg_t    cmd_reg,
    output var ssr_part_t   cmd_part,
    output var logic [15:0] cmd_wdata,
    // Answer lines.
    input wire logic        rsp_valid,
    input wire logic [15:0] rsp_data
);
    // Idle request lines from time zero.
    initial begin
        cmd_valid = 1'b0;
        cmd_op    = SSR_OP_NONE;
        cmd_reg   = SSR_REG_OPER;
        cmd_part  = SSR_PART_COND;
        cmd_wdata = 16'h0000;
    end

    // One request per call; an event read returns the latched bits and clears them.
    task automatic xfer(input ssr_op_t op, input ssr_reg_t rg, input ssr_part_t pt,
                        input logic [15:0] wd, output logic [15:0] rd);
        @(posedge core_clk);
        cmd_valid <= 1'b1;
        cmd_op    <= op;
        cmd_reg   <= rg;
        cmd_part  <= pt;
        cmd_wdata <= wd;
        @(posedge core_clk);
        // Released data shows the inverse, so a stale word cannot pass.
        cmd_valid <= 1'b0;
        cmd_op    <= SSR_OP_NONE;
        cmd_wdata <= ~wd;
        #1;
        rd = (rsp_valid === 1'b1) ? rsp_data : 16'hxxxx;
    endtask
endmodule
`default_nettype wire

//--- test/ssr_status_checker.sv
`timescale 1ns/100ps
`default_nettype none
module ssr_status_checker
    import ssr_pkg::*;
(
    // Clock and reset.
    input wire logic        core_clk,
    input wire logic        rst,
    // Controller side.
    input wire logic        cmd_valid,
    input wire ssr_op_t     cmd_op,
    input wire logic        rsp_valid,
    input wire logic [15:0] rsp_data,
    // Status side.
    input wire logic        out_queue_not_empty,
    input wire logic        err_push,
    input wire logic        err_full,
    input wire logic [7:0]  status_byte,
    input wire logic        srq_pulse
);
    // One clock domain, so reset masks every check here.
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    answer_due_a: assert property (cmd_valid && cmd_op != SSR_OP_NONE |=> rsp_valid)
        else $error("request got no answer");
    quiet_bus_a: assert property (!cmd_valid |=> !rsp_valid)
        else $error("answer without request");
    data_hold_a: assert property (!cmd_valid |=> $stable(rsp_data))
        else $error("answer data moved without request");
    top_bit_a: assert property (rsp_valid |-> rsp_data[15] == 1'b0)
        else $error("answer top bit set");
    unused_bits_a: assert property (rsp_valid |-> status_byte[1:0] == 2'b00)
        else $error("unused status bits set");
    // The first sample after release still sees the reset copy of the byte.
    mav_track_a: assert property (!$past(rst) |-> status_byte[4] == $past(out_queue_not_empty))
        else $error("message bit does not follow queue");
    errq_flag_a: assert property (err_push && !err_full |-> ##2 status_byte[2])
        else $error("queue bit missing after push");
    srq_cause_a: assert property (srq_pulse |-> (status_byte & SSR_SRE_MASK) != 8'h00)
        else $error("request pulse without enabled status");
endmodule

bind ssr_status_top ssr_status_checker chk (.core_clk(core_clk), .rst(rst),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .out_queue_not_empty(out_queue_not_empty), .err_push(err_push), .err_full(err_full),
    .status_byte(status_byte), .srq_pulse(srq_pulse));
`default_nettype wire

//--- test/ssr_status_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module ssr_status_tb_top
    import ssr_pkg::*;
;
    logic        clk, rst, mav, push, full, cv, rv, srq, srq_seen;
    logic [14:0] oper, ques, std;
    logic [15:0] code, wd, rdat, got;
    logic [7:0]  sbyte;
    ssr_op_t     op;
    ssr_reg_t    rg;
    ssr_part_t   pt;
    int          n_errors = 0;
    int          num_checks = 0;

    ssr_status_top #(.ERRQ_DEPTH(4)) dut (.core_clk(clk), .rst(rst), .oper_cond_in(oper),
        .ques_cond_in(ques), .std_event_in(std), .out_queue_not_empty(mav), .err_push(push),
        .err_code(code), .err_full(full), .cmd_valid(cv), .cmd_op(op), .cmd_reg(rg),
        .cmd_part(pt), .cmd_wdata(wd), .rsp_valid(rv), .rsp_data(rdat),
        .status_byte(sbyte), .srq_pulse(srq));
    ssr_ctl_model ctl (.core_clk(clk), .cmd_valid(cv), .cmd_op(op), .cmd_reg(rg),
        .cmd_part(pt), .cmd_wdata(wd), .rsp_valid(rv), .rsp_data(rdat));

    // Free running clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Request pulses are caught here since they stand only one cycle.
    always @(posedge clk) if (srq === 1'b1) srq_seen <= 1'b1;

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rd(input ssr_reg_t r, input ssr_part_t p, input logic [15:0] exp);
        ctl.xfer(SSR_OP_READ, r, p, 16'h0000, got);
        chk($sformatf("reg %0d part %0d", r, p), exp, got);
    endtask
    task automatic wr(input ssr_reg_t r, input ssr_part_t p, input logic [15:0] d);
        ctl.xfer(SSR_OP_WRITE, r, p, d, got);
    endtask
    // Waits past the two-edge lag of the registered byte before looking.
    task automatic sb(input logic [7:0] m, input logic [7:0] e);
        repeat (3) @(posedge clk);
        #1;
        chk("status byte", {8'h00, e}, {8'h00, sbyte & m});
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // The tests need under a thousand cycles, so this limit only cuts a hang.
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        conclude();
    end

    initial begin
        rst = 1'b1; mav = 1'b0; push = 1'b0; code = 16'h0000; srq_seen = 1'b0;
        oper = 15'h0000; ques = 15'h0000; std = 15'h0000;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (int r = 0; r < 3; r++) begin
            rd(ssr_reg_t'(r), SSR_PART_PTR, SSR_PTR_RST);
            rd(ssr_reg_t'(r), SSR_PART_NTR, 16'h0000);
            rd(ssr_reg_t'(r), SSR_PART_EVENT, 16'h0000);
            rd(ssr_reg_t'(r), SSR_PART_ENABLE, 16'h0000);
        end
        $display("test reset done");
        @(posedge clk) oper <= 15'h5a3c;
        wr(SSR_REG_OPER, SSR_PART_COND, 16'hffff);
        rd(SSR_REG_OPER, SSR_PART_COND, 16'h5a3c);
        rd(SSR_REG_OPER, SSR_PART_COND, 16'h5a3c);
        rd(SSR_REG_OPER, SSR_PART_EVENT, 16'h5a3c);
        wr(SSR_REG_OPER, SSR_PART_PTR, 16'h8001);
        rd(SSR_REG_OPER, SSR_PART_PTR, 16'h0001);
        wr(SSR_REG_OPER, SSR_PART_NTR, 16'h0006);
        @(posedge clk) oper <= 15'h5a3b;
        wr(SSR_REG_OPER, SSR_PART_EVENT, 16'hffff);
        rd(SSR_REG_OPER, SSR_PART_EVENT, 16'h0005);
        rd(SSR_REG_OPER, SSR_PART_EVENT, 16'h0000);
        $display("test transitions done");
        wr(SSR_REG_OPER, SSR_PART_ENABLE, 16'h0001);
        @(posedge clk) oper <= 15'h5a3a;
        @(posedge clk) oper <= 15'h5a3b;
        sb(8'h80, 8'h80);
        srq_seen <= 1'b0;
        wr(SSR_REG_STB, SSR_PART_ENABLE, 16'hffff);
        rd(SSR_REG_STB, SSR_PART_ENABLE, {8'h00, SSR_SRE_MASK});
        rd(SSR_REG_OPER, SSR_PART_EVENT, 16'h0001);
        sb(8'h80, 8'h00);
        // Enabling a bit that already stands asks nothing; only a fresh rise does.
        chk("request early", 16'h0000, {15'h0000, srq_seen});
        @(posedge clk) oper <= 15'h5a3a;
        @(posedge clk) oper <= 15'h5a3b;
        sb(8'hc0, 8'hc0);
        chk("request seen", 16'h0001, {15'h0000, srq_seen});
        rd(SSR_REG_OPER, SSR_PART_EVENT, 16'h0001);
        sb(8'h80, 8'h00);
        wr(SSR_REG_STB, SSR_PART_ENABLE, 16'h0000);
        $display("test summary done");
        wr(SSR_REG_ESR, SSR_PART_ENABLE, 16'h0008);
        @(posedge clk) std <= 15'h0018;
        @(posedge clk) std <= 15'h0000;
        sb(8'h20, 8'h20);
        rd(SSR_REG_ESR, SSR_PART_EVENT, 16'h0018);
        @(posedge clk) std <= 15'h0010;
        @(posedge clk) std <= 15'h0000;
        sb(8'h20, 8'h00);
        wr(SSR_REG_QUES, SSR_PART_ENABLE, 16'h0002);
        @(posedge clk) ques <= 15'h0002;
        sb(8'h08, 8'h08);
        @(posedge clk) mav <= 1'b1;
        sb(8'h10, 8'h10);
        @(posedge clk) mav <= 1'b0;
        sb(8'h10, 8'h00);
        $display("test hierarchy done");
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            push <= 1'b1;
            code <= 16'h0e10 + 16'(i);
        end
        @(posedge clk) push <= 1'b0;
        #1;
        chk("queue full", 16'h0001, {15'h0000, full});
        sb(8'h07, 8'h04);
        for (int i = 0; i < 5; i++) begin
            ctl.xfer(SSR_OP_POP, SSR_REG_STB, SSR_PART_COND, 16'h0000, got);
            chk("pop", (i < 4) ? 16'h0e10 + 16'(i) : 16'h0000, got);
        end
        sb(8'h04, 8'h00);
        wr(SSR_REG_STB, SSR_PART_COND, 16'h00ff);
        rd(SSR_REG_STB, SSR_PART_COND, 16'h0008);
        rd(SSR_REG_STB, SSR_PART_EVENT, 16'h0008);
        $display("test error queue done");
        conclude();
    end
endmodule
`default_nettype wire
